// [src/mpfs_sequencer.sv]
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
// Function
// - Go runs steps from 0 upward, ending after step-count plus one steps.
// - Transmit shifts bytes 0 to 3 cyclically in lane width for the step length.
// - With DMA enabled, a transmit last step uses DMA; a refill is requested after every four bytes unless the step ends there.
// - Filler step sends 8'hFF per byte, ignoring the step word.
// - Receive step writes bytes cyclically into word positions 0 through 3.
// - DMA receive step requests DMA whenever the word is filled.
// - Poll compares masked status byte with compare value; match ends the step.
// - Poll without match ends after the retry limit and sets the fault flag.
// - Retry limit 8'h00 polls endlessly until match or soft reset.
// - DMA receive clears go at serial end; done waits for DMA completion.
// - Communication end pulses the end event and clears go.
// - Order select clear puts byte 0 in bits 31:24; set reverses.
// - Poll word: limit 31:24, mask 23:16, compare 15:8, sampled 7:0.
// - Lane field 0 single, 1 dual, 2 quad; 3 prohibited.
// - Operation field 0 transmit, 1 filler, 2 receive, 3 poll.
module mpfs_sequencer (
	// System
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        link_clk,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// DMA
	output logic             dma_req,
	input  wire logic        dma_ack,
	// Flash link
	output logic             flash_chip_select_n,
	output logic             flash_sclk,
	input  wire logic [3:0]  flash_io_in,
	output logic      [3:0]  flash_io_out,
	output logic      [3:0]  flash_io_oe,
	// Events
	output logic             comm_end_pulse
);
	import mpfs_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_ISSUE, ST_WAIT, ST_REFILL, ST_DRAIN,
		ST_NEXT} mpfs_state_e;

	// ==========================================
	// Storage
	mpfs_step_s      step_cfg_reg  [STEPS];
	logic [31:0]     step_data_reg [STEPS];
	logic [STEPS-1:0] step_done_reg, step_fault_reg;
	logic            go_reg, done_reg, fault_reg, dma_en_reg, order_reg, cs_n_reg, end_reg;
	logic [2:0]      cnt_reg, step_reg;
	logic [LEN_W-1:0] left_reg;
	logic [1:0]      idx_reg;
	logic [7:0]      tries_reg;
	logic [31:0]     rdata_reg;
	mpfs_state_e     state_reg;
	mpfs_job_s       job_reg;
	logic            req_tgl_reg, ack_s1_reg, ack_s2_reg, ack_tgl_reg;
	logic [7:0]      link_rx_reg;

	// ==========================================
	// Register decode
	wire        wr_ctrl   = reg_wr && (reg_addr == CTRL_OFS);
	wire [7:0]  sc_off    = reg_addr - STEP_CTRL_BASE;
	wire [7:0]  sd_off    = reg_addr - STEP_DATA_BASE;
	wire        sc_hit    = (reg_addr >= STEP_CTRL_BASE) && (sc_off < STEP_SPAN)
		&& (reg_addr[1:0] == 2'h0);
	wire        sd_hit    = (reg_addr >= STEP_DATA_BASE) && (sd_off < STEP_SPAN)
		&& (reg_addr[1:0] == 2'h0);
	wire [2:0]  sc_idx    = sc_off[4:2];
	wire [2:0]  sd_idx    = sd_off[4:2];
	wire        link_idle = (ack_s2_reg == req_tgl_reg);
	wire        srst      = wr_ctrl && reg_wdata[CTL_SRST];
	wire        start     = wr_ctrl && reg_wdata[CTL_GO] && !go_reg && (state_reg == ST_IDLE)
		&& link_idle && !srst;

	// ==========================================
	// Current step decode
	mpfs_step_s cur;
	assign cur = step_cfg_reg[step_reg];
	wire [31:0] cur_word   = step_data_reg[step_reg];
	wire        last_step  = (step_reg == cnt_reg);
	wire        dma_step   = dma_en_reg && last_step;
	wire [1:0]  slot       = order_reg ? idx_reg : ~idx_reg;
	wire [7:0]  word_byte  = cur_word[{slot, 3'b000} +: 8];
	wire        is_drive   = (cur.op == OP_TX) || (cur.op == OP_FILL);
	// Only transmit steps send word bytes; the rest shift out all ones, which dual and quad receive and poll steps leave undriven
	wire [7:0]  tx_byte    = (cur.op == OP_TX) ? word_byte : FILLER_BYTE;
	wire [7:0]  p_limit    = cur_word[PL_LIMIT_LO +: 8];
	wire [7:0]  p_mask     = cur_word[PL_MASK_LO +: 8];
	wire [7:0]  p_exp      = cur_word[PL_EXP_LO +: 8];
	wire        p_match    = ((link_rx_reg & p_mask) == p_exp);
	wire [7:0]  tries_inc  = tries_reg + 8'h01;
	wire        ack_ev     = (state_reg == ST_WAIT) && link_idle;
	wire        word_end   = (idx_reg == LAST_SLOT);
	wire        len_end    = (left_reg == {{(LEN_W-1){1'b0}}, 1'b1});
	wire        poll_give  = (p_limit != POLL_ENDLESS) && (tries_inc == p_limit);
	wire        fault_set  = ack_ev && (cur.op == OP_POLL) && !p_match && poll_give;
	wire        done_set   = (state_reg == ST_NEXT) && last_step;
	wire        hw_wr      = ack_ev && ((cur.op == OP_RX) || (cur.op == OP_POLL));
	wire [31:0] rx_merged  = (cur.op == OP_POLL)
		? {cur_word[31:8], link_rx_reg}
		: (cur_word & ~(32'h0000_00FF << {slot, 3'b000}))
			| ({24'h00_0000, link_rx_reg} << {slot, 3'b000});

	// ==========================================
	// Register read mux
	wire [31:0] sc_word = {10'h000, step_cfg_reg[sc_idx].lane, step_cfg_reg[sc_idx].len,
		2'h0, step_cfg_reg[sc_idx].op, 1'b0, step_fault_reg[sc_idx], step_done_reg[sc_idx],
		(state_reg != ST_IDLE) && (state_reg != ST_DRAIN) && (step_reg == sc_idx)};
	wire [31:0] ctl_word = {21'h00_0000, 1'b0, order_reg, dma_en_reg, 1'b0, cnt_reg, 1'b0,
		fault_reg, done_reg, go_reg};
	wire [31:0] rd_word  = (reg_addr == CTRL_OFS) ? ctl_word
		: sc_hit ? sc_word : sd_hit ? step_data_reg[sd_idx] : WORD_ZERO;

	always_ff @(posedge clk) begin
		if (rst)
			rdata_reg <= WORD_ZERO;
		else if (reg_rd)
			rdata_reg <= rd_word;
		else
			rdata_reg <= WORD_ZERO;
	end

	// ==========================================
	// Step configuration and data words
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < STEPS; i++) begin
				step_cfg_reg[i]  <= '0;
				step_data_reg[i] <= WORD_ZERO;
			end
		end else begin
			if (reg_wr && sc_hit)
				step_cfg_reg[sc_idx] <= {reg_wdata[SC_LANE_LO +: 2],
					reg_wdata[SC_LEN_LO +: LEN_W], reg_wdata[SC_OP_LO +: 2]};
			// Hardware capture wins; DMA and software write only between bytes
			if (hw_wr)
				step_data_reg[step_reg] <= rx_merged;
			else if (reg_wr && sd_hit)
				step_data_reg[sd_idx] <= reg_wdata;
		end
	end

	// ==========================================
	// Control flags: hardware set wins over software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			go_reg     <= 1'b0;
			done_reg   <= 1'b0;
			fault_reg  <= 1'b0;
			cnt_reg    <= 3'h0;
			dma_en_reg <= 1'b0;
			order_reg  <= 1'b0;
		end else begin
			if (wr_ctrl && !go_reg) begin
				cnt_reg    <= reg_wdata[CTL_CNT_LO +: 3];
				dma_en_reg <= reg_wdata[CTL_DMA];
				order_reg  <= reg_wdata[CTL_ORDER];
			end
			if (start)
				go_reg <= 1'b1;
			else if (srst || done_set || (state_reg == ST_DRAIN))
				go_reg <= 1'b0;
			done_reg  <= done_set
				|| (done_reg && !start && !(wr_ctrl && !reg_wdata[CTL_DONE]));
			fault_reg <= fault_set
				|| (fault_reg && !start && !(wr_ctrl && !reg_wdata[CTL_FAULT]));
		end
	end

	// ==========================================
	// Step sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg      <= ST_IDLE;
			step_reg       <= 3'h0;
			left_reg       <= '0;
			idx_reg        <= 2'h0;
			tries_reg      <= 8'h00;
			job_reg        <= '0;
			req_tgl_reg    <= 1'b0;
			step_done_reg  <= '0;
			step_fault_reg <= '0;
		end else if (srst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: if (start) begin
					step_reg       <= 3'h0;
					step_done_reg  <= '0;
					step_fault_reg <= '0;
					state_reg      <= ST_LOAD;
				end
				ST_LOAD: begin
					idx_reg   <= 2'h0;
					left_reg  <= cur.len;
					tries_reg <= 8'h00;
					state_reg <= ((cur.op == OP_POLL) || (cur.len != '0)) ? ST_ISSUE : ST_NEXT;
				end
				ST_ISSUE: begin
					job_reg     <= '{tx_byte: tx_byte, lane: cur.lane, drive: is_drive};
					req_tgl_reg <= ~req_tgl_reg;
					state_reg   <= ST_WAIT;
				end
				ST_WAIT: if (ack_ev) begin
					if (cur.op == OP_POLL) begin
						tries_reg <= tries_inc;
						if (fault_set)
							step_fault_reg[step_reg] <= 1'b1;
						state_reg <= (p_match || poll_give) ? ST_NEXT : ST_ISSUE;
					end else begin
						idx_reg  <= idx_reg + 2'h1;
						left_reg <= left_reg - {{(LEN_W-1){1'b0}}, 1'b1};
						if (len_end)
							state_reg <= (dma_step && (cur.op == OP_RX)) ? ST_DRAIN : ST_NEXT;
						else if (dma_step && word_end && (cur.op != OP_FILL))
							state_reg <= ST_REFILL;
						else
							state_reg <= ST_ISSUE;
					end
				end
				ST_REFILL: if (dma_ack)
					state_reg <= ST_ISSUE;
				ST_DRAIN: if (dma_ack)
					state_reg <= ST_NEXT;
				ST_NEXT: begin
					step_done_reg[step_reg] <= 1'b1;
					step_reg  <= step_reg + 3'h1;
					state_reg <= last_step ? ST_IDLE : ST_LOAD;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Chip select, end event, acknowledge synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_n_reg   <= 1'b1;
			end_reg    <= 1'b0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end else begin
			// Stay released from drain through the closing step
			cs_n_reg   <= (state_reg == ST_IDLE) || (state_reg == ST_DRAIN)
				|| (cs_n_reg && (state_reg == ST_NEXT));
			end_reg    <= done_set;
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	assign reg_rdata           = rdata_reg;
	assign dma_req             = (state_reg == ST_REFILL) || (state_reg == ST_DRAIN);
	assign flash_chip_select_n = cs_n_reg;
	assign comm_end_pulse      = end_reg;

	// ==========================================
	// Link domain: one byte per request toggle
	logic       lrst_s1_reg, lrst_reg, req_s1_reg, req_s2_reg, busy_reg;
	logic       sclk_reg, drive_reg;
	logic [1:0] phase_reg, lane_reg;
	logic [2:0] grp_reg;
	logic [7:0] sh_reg;
	logic [3:0] in_s1_reg, in_s2_reg, out_reg;

	// Prohibited lane code falls back to single lane, except that receive and poll steps leave flash_io_oe at 0
	wire [2:0] grp_init = (job_reg.lane == LANE_FOUR) ? 3'h1
		: (job_reg.lane == LANE_TWO) ? 3'h3 : 3'h7;
	wire [7:0] sh_next  = (lane_reg == LANE_FOUR) ? {sh_reg[3:0], in_s2_reg}
		: (lane_reg == LANE_TWO) ? {sh_reg[5:0], in_s2_reg[1:0]}
		: {sh_reg[6:0], in_s2_reg[1]};
	wire [3:0] out_next = (lane_reg == LANE_FOUR) ? sh_next[7:4]
		: (lane_reg == LANE_TWO) ? {2'h3, sh_next[7:6]} : {3'h7, sh_next[7]};
	wire [3:0] lane_oe  = (lane_reg == LANE_FOUR) ? 4'hF : (lane_reg == LANE_TWO) ? 4'h3 : 4'h1;
	wire       new_job  = !busy_reg && (req_s2_reg != ack_tgl_reg);
	wire [3:0] out_init = (job_reg.lane == LANE_FOUR) ? job_reg.tx_byte[7:4]
		: (job_reg.lane == LANE_TWO) ? {2'h3, job_reg.tx_byte[7:6]} : {3'h7, job_reg.tx_byte[7]};

	always_ff @(posedge link_clk) begin
		lrst_s1_reg <= rst;
		lrst_reg    <= lrst_s1_reg;
		in_s1_reg   <= flash_io_in;
		in_s2_reg   <= in_s1_reg;
	end

	always_ff @(posedge link_clk) begin
		if (lrst_reg) begin
			req_s1_reg  <= 1'b0;
			req_s2_reg  <= 1'b0;
			ack_tgl_reg <= 1'b0;
			busy_reg    <= 1'b0;
			sclk_reg    <= 1'b0;
			drive_reg   <= 1'b0;
			phase_reg   <= 2'h0;
			lane_reg    <= LANE_ONE;
			grp_reg     <= 3'h0;
			sh_reg      <= 8'h00;
			out_reg     <= 4'hF;
			link_rx_reg <= 8'h00;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			sclk_reg   <= busy_reg && (phase_reg[0] ^ phase_reg[1] ? phase_reg == 2'h1 :
				phase_reg == 2'h0);
			if (new_job) begin
				busy_reg  <= 1'b1;
				phase_reg <= 2'h0;
				lane_reg  <= job_reg.lane;
				drive_reg <= job_reg.drive;
				grp_reg   <= grp_init;
				sh_reg    <= job_reg.tx_byte;
				out_reg   <= out_init;
			end else if (busy_reg) begin
				phase_reg <= phase_reg + 2'h1;
				// Sample late: synchronised input trails the rising edge by two cycles
				if (phase_reg == PH_SAMPLE) begin
					sh_reg  <= sh_next;
					out_reg <= out_next;
					grp_reg <= grp_reg - 3'h1;
					if (grp_reg == 3'h0) begin
						busy_reg    <= 1'b0;
						link_rx_reg <= sh_next;
						ack_tgl_reg <= req_s2_reg;
					end
				end
			end
		end
	end

	assign flash_sclk   = sclk_reg;
	assign flash_io_out = out_reg;
	assign flash_io_oe  = drive_reg ? lane_oe : (lane_reg == LANE_ONE ? 4'h1 : 4'h0);

	// ==========================================
	// Checks
	start_step0_a: assert property (@(posedge clk) disable iff (rst)
		start |=> (step_reg == 3'h0) && (state_reg == ST_LOAD))
		else $error("start did not begin at step 0");
	cs_held_a: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_WAIT) || (state_reg == ST_REFILL) |-> !flash_chip_select_n)
		else $error("chip select released inside a communication");
	filler_byte_a: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ISSUE) && (cur.op == OP_FILL) |=> job_reg.tx_byte == FILLER_BYTE)
		else $error("filler step sent other than all ones");
	tx_order_a: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ISSUE) && (cur.op == OP_TX) && !order_reg && (idx_reg == 2'h0)
		|=> job_reg.tx_byte == $past(cur_word[31:24]))
		else $error("first transmit byte not from top of word");
	rx_place_a: assert property (@(posedge clk) disable iff (rst || srst)
		ack_ev && (cur.op == OP_RX) && order_reg && (idx_reg == 2'h0)
		|=> cur_word[7:0] == $past(link_rx_reg))
		else $error("receive byte 0 misplaced with order set");
	poll_read_a: assert property (@(posedge clk) disable iff (rst || srst)
		ack_ev && (cur.op == OP_POLL) |=> cur_word[7:0] == $past(link_rx_reg))
		else $error("poll sample not stored");
	poll_match_a: assert property (@(posedge clk) disable iff (rst || srst)
		ack_ev && (cur.op == OP_POLL) && p_match |=> (state_reg == ST_NEXT) && !fault_reg)
		else $error("poll match did not end step cleanly");
	poll_fault_a: assert property (@(posedge clk) disable iff (rst || srst)
		fault_set |=> fault_reg && (state_reg == ST_NEXT) ##1 step_fault_reg != '0)
		else $error("poll limit did not fault");
	endless_poll_a: assert property (@(posedge clk) disable iff (rst || srst)
		ack_ev && (cur.op == OP_POLL) && (p_limit == POLL_ENDLESS) && !p_match
		|=> state_reg == ST_ISSUE)
		else $error("endless poll stopped");
	refill_req_a: assert property (@(posedge clk) disable iff (rst || srst)
		ack_ev && (cur.op == OP_TX) && dma_step && word_end && !len_end
		|=> dma_req && (state_reg == ST_REFILL))
		else $error("no refill after four bytes");
	drain_done_a: assert property (@(posedge clk) disable iff (rst || srst)
		$rose(state_reg == ST_DRAIN) |-> dma_req && !done_reg ##1 !go_reg && !done_reg)
		else $error("drain flags wrong");
	end_event_a: assert property (@(posedge clk) disable iff (rst || srst)
		done_set |=> comm_end_pulse && !go_reg && done_reg ##1 !comm_end_pulse)
		else $error("end event or go clear missing");

endmodule : mpfs_sequencer

// [src/mpfs_pkg.sv]
package mpfs_pkg;

	// ==========================================
	// Register map
	localparam int unsigned STEPS          = 8;
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STEP_CTRL_BASE = 8'h10;
	localparam logic [7:0]  STEP_DATA_BASE = 8'h30;
	localparam logic [7:0]  STEP_SPAN      = 8'h20;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

	// ==========================================
	// Control register fields
	localparam int unsigned CTL_GO     = 0;
	localparam int unsigned CTL_DONE   = 1;
	localparam int unsigned CTL_FAULT  = 2;
	localparam int unsigned CTL_CNT_LO = 4;
	localparam int unsigned CTL_DMA    = 8;
	localparam int unsigned CTL_ORDER  = 9;
	localparam int unsigned CTL_SRST   = 10;

	// ==========================================
	// Step control fields
	localparam int unsigned SC_OP_LO   = 4;
	localparam int unsigned SC_LEN_LO  = 8;
	localparam int unsigned SC_LANE_LO = 20;
	localparam int unsigned LEN_W      = 12;

	// ==========================================
	// Step operations and lane widths
	localparam logic [1:0] OP_TX     = 2'h0;
	localparam logic [1:0] OP_FILL   = 2'h1;
	localparam logic [1:0] OP_RX     = 2'h2;
	localparam logic [1:0] OP_POLL   = 2'h3;
	localparam logic [1:0] LANE_ONE  = 2'h0;
	localparam logic [1:0] LANE_TWO  = 2'h1;
	localparam logic [1:0] LANE_FOUR = 2'h2;

	// ==========================================
	// Poll word layout and constants
	localparam int unsigned PL_LIMIT_LO = 24;
	localparam int unsigned PL_MASK_LO  = 16;
	localparam int unsigned PL_EXP_LO   = 8;
	localparam int unsigned PL_READ_LO  = 0;
	localparam logic [7:0]  FILLER_BYTE = 8'hFF;
	localparam logic [7:0]  POLL_ENDLESS = 8'h00;
	localparam logic [1:0]  LAST_SLOT   = 2'h3;

	// ==========================================
	// Link bit timing, in link clock phases
	localparam logic [1:0] PH_SAMPLE = 2'h3;

	typedef struct packed {
		logic [1:0]       lane;
		logic [LEN_W-1:0] len;
		logic [1:0]       op;
	} mpfs_step_s;

	typedef struct packed {
		logic [7:0] tx_byte;
		logic [1:0] lane;
		logic       drive;
	} mpfs_job_s;

endpackage : mpfs_pkg

// [verification/mpfs_flash_model.sv]
`timescale 1ns/10ps
module mpfs_flash_model (
	// Link pins
	input  wire logic       flash_chip_select_n,
	input  wire logic       flash_sclk,
	input  wire logic [3:0] flash_io_out,
	input  wire logic [3:0] flash_io_oe,
	output logic      [3:0] flash_io_in
);
	int         wq[$];
	logic [7:0] got_q[$];
	logic [7:0] rseed  = 8'h00;
	int         frames = 0;
	int         bitn   = 0;
	logic [7:0] sh     = 8'h00;

	// ==========================================
	// Byte k of a frame answers rseed + 29 * k
	function automatic int wid(int b);
		return (b < wq.size()) ? wq[b] : 1;
	endfunction : wid

	// New group on the falling edge, steady over the next rising edge
	task automatic drive();
		int         w;
		logic [7:0] t;
		w = wid(bitn / 8);
		t = (rseed + 8'(bitn / 8 * 29)) << (bitn % 8);
		t = t >> (8 - w);
		flash_io_in = (w == 1) ? {2'b00, t[0], 1'b0} : t[3:0];
	endtask : drive

	// Deselected lines must not look like the last bit sent
	initial flash_io_in = 4'h5;
	always #7 if (flash_chip_select_n) flash_io_in = ~flash_io_in;

	always @(negedge flash_chip_select_n) begin
		bitn = 0;
		frames++;
		drive();
	end
	always @(negedge flash_sclk) if (!flash_chip_select_n) drive();

	// Only bytes sent with lane 0 enabled are recorded
	always @(posedge flash_sclk) begin
		int w;
		w = wid(bitn / 8);
		if (!flash_chip_select_n) begin
			sh = (sh << w) | 8'(flash_io_out & 4'((1 << w) - 1));
			bitn += w;
			if (bitn % 8 == 0 && flash_io_oe[0]) got_q.push_back(sh);
		end
	end
endmodule : mpfs_flash_model

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
	import mpfs_pkg::*;

	// ==========================================
	// Design signals
	logic        clk = 1'b0, link_clk = 1'b0, rst = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, dma_ack = 1'b0;
	logic [31:0] reg_rdata;
	logic        dma_req, flash_chip_select_n, flash_sclk, comm_end_pulse;
	logic [3:0]  flash_io_in, flash_io_out, flash_io_oe;

	// ==========================================
	// Bench model state
	int          error_cnt = 0, n_compared = 0, ends = 0, nst;
	int          len[8];
	logic [1:0]  op[8], ln[8];
	logic [31:0] dw[8], fin[8], v;
	logic        ord, dma, flt;
	logic [7:0]  rs;
	logic [7:0]  expq[$];
	logic [31:0] fillq[$], drq[$];

	always #5 clk = ~clk;
	initial begin
		#2.3;
		forever #6 link_clk = ~link_clk;
	end
	always @(posedge clk) if (comm_end_pulse === 1'b1) ends++;

	mpfs_sequencer mpfs_sequencer_inst (.clk(clk), .rst(rst), .link_clk(link_clk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dma_req(dma_req), .dma_ack(dma_ack),
		.flash_chip_select_n(flash_chip_select_n), .flash_sclk(flash_sclk),
		.flash_io_in(flash_io_in), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
		.comm_end_pulse(comm_end_pulse));
	mpfs_flash_model mpfs_flash_model_inst (.flash_chip_select_n(flash_chip_select_n),
		.flash_sclk(flash_sclk), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
		.flash_io_in(flash_io_in));

	// ==========================================
	// Helpers
	function automatic logic [7:0] resp(int k);
		return rs + 8'(k * 29);
	endfunction : resp

	function automatic int slot(int j);
		return ord ? 8 * (j % 4) : 24 - 8 * (j % 4);
	endfunction : slot

	function automatic logic [31:0] ctlw();
		return (32'(nst - 1) << CTL_CNT_LO) | (32'(dma) << CTL_DMA) | (32'(ord) << CTL_ORDER);
	endfunction : ctlw

	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			error_cnt++;
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	task automatic st(int s, logic [1:0] o, logic [1:0] l, int n, logic [31:0] d);
		op[s]  = o;
		ln[s]  = l;
		len[s] = n;
		dw[s]  = d;
	endtask : st

	task automatic cfg();
		for (int s = 0; s < nst; s++) begin
			wr(STEP_CTRL_BASE + 8'(4 * s), {10'h000, ln[s], 12'(len[s]), 2'b00, op[s], 4'h0});
			wr(STEP_DATA_BASE + 8'(4 * s), dw[s]);
		end
		mpfs_flash_model_inst.got_q.delete();
		mpfs_flash_model_inst.frames = 0;
		mpfs_flash_model_inst.rseed  = rs;
		wr(CTRL_OFS, ctlw() | 32'h0000_0001);
	endtask : cfg

	// ==========================================
	// One communication: predict, run, serve DMA, compare
	task automatic run(string nm);
		int          b, w, t, e0;
		logic [31:0] wd;
		logic [7:0]  r;
		logic [7:0]  dadr;
		b = 0;
		flt = 1'b0;
		dadr = STEP_DATA_BASE + 8'(4 * (nst - 1));
		expq.delete();
		fillq.delete();
		drq.delete();
		mpfs_flash_model_inst.wq.delete();
		for (int s = 0; s < nst; s++) begin
			w = (ln[s] == LANE_FOUR) ? 4 : (ln[s] == LANE_TWO) ? 2 : 1;
			wd = dw[s];
			for (int j = 0; j < len[s] || op[s] == OP_POLL; j++) begin
				r = resp(b);
				mpfs_flash_model_inst.wq.push_back(w);
				b++;
				if (op[s] == OP_TX && j > 0 && j % 4 == 0 && dma && s == nst - 1) begin
					wd = $urandom;
					fillq.push_back(wd);
				end
				case (op[s])
					OP_TX: expq.push_back(8'(wd >> slot(j)));
					OP_FILL: expq.push_back(FILLER_BYTE);
					default: if (w == 1) expq.push_back(8'hFF);
				endcase
				if (op[s] == OP_RX) wd[slot(j) +: 8] = r;
				if (op[s] == OP_RX && dma && s == nst - 1 && (j % 4 == 3 || j == len[s] - 1))
					drq.push_back(wd);
				if (op[s] == OP_POLL && ((r & wd[23:16]) == wd[15:8]
					|| j + 1 == int'(wd[31:24]) || j > 2000)) begin
					flt = flt | ((r & wd[23:16]) != wd[15:8]);
					wd[7:0] = r;
					break;
				end
			end
			fin[s] = wd;
		end
		cfg();
		e0 = ends;
		for (t = 0; t < 30000 && ends == e0; t++) begin
			@(posedge clk);
			#1;
			if (dma_req === 1'b1) begin
				if (op[nst - 1] == OP_TX) begin
					wr(dadr, fillq.pop_front());
				end else begin
					rd(dadr, v);
					chk("drained word", drq.pop_front(), v);
					if (drq.size() == 0) begin
						rd(CTRL_OFS, v);
						chk("go and done at drain", 32'h0, 32'(v[1:0]));
					end
				end
				@(posedge clk);
				dma_ack <= 1'b1;
				@(posedge clk);
				dma_ack <= 1'b0;
			end
		end
		if (t >= 30000) begin
			$display("[ERR] %s end expected 1 seen 0", nm);
			error_cnt++;
			results();
		end
		repeat (4) @(posedge clk);
		chk("chip select idle", 32'h1, 32'(flash_chip_select_n));
		chk("frames", 32'h1, 32'(mpfs_flash_model_inst.frames));
		chk("end pulses", 32'h1, 32'(ends - e0));
		chk("tx count", 32'(expq.size()), 32'(mpfs_flash_model_inst.got_q.size()));
		foreach (expq[i])
			chk("tx byte", 32'(expq[i]), 32'(mpfs_flash_model_inst.got_q[i]));
		rd(CTRL_OFS, v);
		chk("control", ctlw() | (32'(flt) << CTL_FAULT) | 32'h0000_0002, v);
		for (int s = 0; s < nst; s++) begin
			rd(STEP_DATA_BASE + 8'(4 * s), v);
			chk("step word", fin[s], v);
			rd(STEP_CTRL_BASE + 8'(4 * s), v);
			chk("step control", {10'h000, ln[s], 12'(len[s]), 2'b00, op[s], 1'b0,
				flt && op[s] == OP_POLL, 2'b10}, v);
		end
		$display("%s finished", nm);
	endtask : run

	// ==========================================
	// Main sequence; receive and poll only ever last, never first
	initial begin
		void'($urandom(32'hbfbac552));
		rs = 8'($urandom);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		rd(8'h04, v);
		chk("unmapped read", 32'h0, v);
		rd(8'h50, v);
		chk("unmapped read", 32'h0, v);
		{ord, dma, nst} = {1'b0, 1'b0, 32'd4};
		st(0, OP_TX, LANE_ONE, 1, $urandom);
		st(1, OP_TX, LANE_ONE, 4, $urandom);
		st(2, OP_FILL, LANE_ONE, 2, $urandom);
		st(3, OP_RX, LANE_ONE, 4, 32'h0000_0000);
		run("single lane mix");
		ord = 1'b1;
		st(1, OP_TX, LANE_FOUR, 4, $urandom);
		st(2, OP_FILL, LANE_FOUR, 2, $urandom);
		st(3, OP_RX, LANE_FOUR, 5, $urandom);
		run("quad swapped order");
		{ord, nst} = {1'b0, 32'd2};
		st(1, OP_POLL, LANE_TWO, 0, {8'h10, 8'hF0, resp(3) & 8'hF0, 8'h00});
		run("poll match");
		nst = 3;
		st(0, OP_TX, LANE_ONE, 0, $urandom);
		st(1, OP_TX, LANE_TWO, 3, $urandom);
		st(2, OP_POLL, LANE_ONE, 0, {8'h03, 8'hFF, resp(3) ^ 8'h80, 8'h00});
		run("poll limit");
		nst = 2;
		st(0, OP_TX, LANE_ONE, 1, $urandom);
		st(1, OP_POLL, LANE_FOUR, 0, {8'h00, 8'hFF, resp(5), 8'h00});
		run("poll endless match");
		st(1, OP_POLL, LANE_ONE, 0, 32'h0000_0100);
		mpfs_flash_model_inst.wq.delete();
		cfg();
		repeat (500) @(posedge clk);
		rd(CTRL_OFS, v);
		chk("endless poll busy", 32'h1, 32'(v[CTL_GO]));
		wr(CTRL_OFS, 32'h0000_0001 << CTL_SRST);
		repeat (20) @(posedge clk);
		rd(CTRL_OFS, v);
		chk("go after soft reset", 32'h0, 32'(v[CTL_GO]));
		repeat (200) @(posedge clk);
		$display("soft reset finished");
		{ord, dma} = {1'b1, 1'b1};
		st(1, OP_TX, LANE_TWO, 10, $urandom);
		run("dma refill");
		ord = 1'b0;
		st(1, OP_RX, LANE_FOUR, 6, 32'h0000_0000);
		run("dma drain");
		results();
	end
endmodule : testbench
